// ===== mms_top.sv
// Management control and status logic of a pluggable optical module.
// Assumes a host drives the sideband pins and a two-wire bus whose clock
// is far slower than core_clk; all pins are synchronised before use.
`timescale 1ns/1ps

// Function
// - Fully functional within 2000 ms of power-on or reset release.
// - Reset recognised only after reset pin held low at least 2 us.
// - Two-wire bus answers within 2000 ms after power-on.
// - Data-not-ready bit clears and interrupt asserts within 2000 ms.
// - Reset pin rising edge leads to fully functional within 2000 ms.
// - Low-power select high enters low power within 100 us.
// - Interrupt pin driven low within 200 ms of a triggering condition.
// - Flags clear on read; interrupt releases within 500 us after stop.
// - Receive loss flag set and interrupt asserted within 100 ms.
// - Transmit fault flag set and interrupt asserted within 200 ms.
// - Any other condition sets its flag and interrupt within 200 ms.
// - Setting a mask bit inhibits that flag's interrupt within 100 ms.
// - Clearing a mask bit resumes that flag's interrupt within 100 ms.
// - Module select asserted enables bus answers within 100 us.
// - Module select deasserted stops bus answers within 100 us.
// - Power-down bit set enters low power within 100 ms.
// - Power-down bit cleared returns full function within 300 ms.
// - Full function is signalled by the ready flag raising the interrupt.
// - Write-triggered latencies count from the edge after the stop bit.
// - Upper page 02 is free user storage.
module mms_top #(
   parameter int INIT_CYCLES = mms_pkg::INIT_CYC
) (
   input  wire logic core_clk,
   input  wire logic rst_n,
   input  wire logic module_reset_n,
   input  wire logic module_select_n,
   input  wire logic low_power_select,
   input  wire logic scl_in,
   input  wire logic sda_in,
   output logic      sda_out,
   output logic      sda_oe,
   input  wire logic rx_los,
   input  wire logic tx_fault,
   input  wire logic other_fault,
   output logic      interrupt_out_n,
   output logic      low_power_mode,
   output logic      data_not_ready
);

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   logic [mms_pkg::NSYNC-1:0] pin_s;

   mms_sync #(
      .W       (mms_pkg::NSYNC),
      .RST_VAL (mms_pkg::SYNC_RST)
   ) u_sync (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .d_in     ({other_fault, tx_fault, rx_los, low_power_select,
                  module_select_n, module_reset_n, sda_in, scl_in}),
      .q_out    (pin_s)
   );

   wire scl_s   = pin_s[mms_pkg::SI_SCL];
   wire sda_s   = pin_s[mms_pkg::SI_SDA];
   wire mrst_s  = pin_s[mms_pkg::SI_RST];
   wire sel_n_s = pin_s[mms_pkg::SI_SEL];
   wire lps_s   = pin_s[mms_pkg::SI_LPS];
   wire [mms_pkg::NFLAG-1:0] cond_s = {1'b0, pin_s[mms_pkg::SI_OTH],
      pin_s[mms_pkg::SI_TXF], pin_s[mms_pkg::SI_LOS]};

   ////////////////////////////////////////////////////////////////////////
   // Reset recognition and initialisation
   logic                       boot_r;
   logic                       hold_r;
   logic                       mrst_q_r;
   logic [mms_pkg::RCNT_W-1:0] rcnt_r;
   logic                       dnr_r;
   logic                       bus_rdy_r;

   mms_tmr_if tif ();

   mms_timer #(
      .CYCLES (INIT_CYCLES)
   ) u_init (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .tif      (tif)
   );

   localparam int                         RMIN_I = mms_pkg::RESET_MIN_CYC;
   localparam logic [mms_pkg::RCNT_W-1:0] RMIN   =
      RMIN_I[mms_pkg::RCNT_W-1:0];

   wire rst_seen = !mrst_s && (rcnt_r == RMIN - 1'b1);
   wire rst_rise = mrst_s && !mrst_q_r && hold_r;
   assign tif.start = boot_r || rst_rise;
   wire init_done = tif.done && !hold_r;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         boot_r   <= 1'b1;
         mrst_q_r <= 1'b1;
         rcnt_r   <= '0;
      end else begin
         boot_r   <= 1'b0;
         mrst_q_r <= mrst_s;
         rcnt_r   <= (mrst_s || rcnt_r == RMIN) ? '0 : rcnt_r + 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         hold_r    <= 1'b0;
         dnr_r     <= 1'b1;
         bus_rdy_r <= 1'b0;
      end else if (rst_seen) begin
         hold_r    <= 1'b1;
         dnr_r     <= 1'b1;
         bus_rdy_r <= 1'b0;
      end else begin
         if (rst_rise) hold_r <= 1'b0;
         if (init_done) begin
            dnr_r     <= 1'b0;
            bus_rdy_r <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Two-wire slave
   mms_pkg::mms_tw_state_type st_r;
   logic       scl_q_r;
   logic       sda_q_r;
   logic [3:0] cnt_r;
   logic [7:0] sh_r;
   logic [7:0] ptr_r;
   logic       ptr_set_r;
   logic       nack_r;
   logic       oe_r;
   logic       cor_r;
   logic       cor_fire;
   logic [7:0] ctrl_r;
   logic [7:0] page_r;
   logic [mms_pkg::NFLAG-1:0] mask_r;
   logic [mms_pkg::NFLAG-1:0] flag_r;
   logic [7:0] user_mem [mms_pkg::USER_DEPTH];

   wire scl_rise = scl_s && !scl_q_r;
   wire scl_fall = !scl_s && scl_q_r;
   wire start_c  = scl_s && scl_q_r && sda_q_r && !sda_s;
   wire stop_c   = scl_s && scl_q_r && !sda_q_r && sda_s;
   wire bus_on   = bus_rdy_r && !sel_n_s;
   wire byte_end = (cnt_r == 4'h8);
   wire dev_hit  = (sh_r[7:1] == mms_pkg::DEV_ADDR);
   wire wr_fire  = scl_fall && st_r == mms_pkg::ST_WR && byte_end &&
                   !ptr_set_r;
   wire wr_user  = wr_fire && ptr_r[7] && page_r == mms_pkg::USER_PAGE;
   wire user_sel = ptr_r[7] && page_r == mms_pkg::USER_PAGE;

   wire [7:0] rd_byte =
      ptr_r[7] ? (user_sel ? user_mem[ptr_r[6:0]] : 8'h00) :
      (ptr_r == mms_pkg::ADDR_STATUS) ? {7'h00, dnr_r} :
      (ptr_r == mms_pkg::ADDR_FLAGS)  ? {4'h0, flag_r} :
      (ptr_r == mms_pkg::ADDR_CTRL)   ? ctrl_r :
      (ptr_r == mms_pkg::ADDR_MASK)   ? {4'h0, mask_r} :
      (ptr_r == mms_pkg::ADDR_PAGE)   ? page_r : 8'h00;

   wire load_rd = scl_fall && ((st_r == mms_pkg::ST_DEV_ACK && sh_r[0]) ||
                  (st_r == mms_pkg::ST_RD_ACK && !nack_r));

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r      <= mms_pkg::ST_IDLE;
         scl_q_r   <= 1'b1;
         sda_q_r   <= 1'b1;
         cnt_r     <= 4'h0;
         sh_r      <= 8'h00;
         ptr_r     <= 8'h00;
         ptr_set_r <= 1'b0;
         nack_r    <= 1'b0;
         oe_r      <= 1'b0;
         cor_r     <= 1'b0;
      end else begin
         scl_q_r <= scl_s;
         sda_q_r <= sda_s;
         if (!bus_on) begin
            st_r  <= mms_pkg::ST_IDLE;
            oe_r  <= 1'b0;
            cor_r <= 1'b0;
         end else if (start_c) begin
            st_r  <= mms_pkg::ST_DEV;
            cnt_r <= 4'h0;
            oe_r  <= 1'b0;
         end else if (stop_c) begin
            st_r  <= mms_pkg::ST_IDLE;
            oe_r  <= 1'b0;
            cor_r <= 1'b0;
         end else if (scl_rise) begin
            case (st_r)
               mms_pkg::ST_DEV, mms_pkg::ST_WR: begin
                  sh_r  <= {sh_r[6:0], sda_s};
                  cnt_r <= cnt_r + 4'h1;
               end
               mms_pkg::ST_RD: cnt_r <= cnt_r + 4'h1;
               mms_pkg::ST_RD_ACK: nack_r <= sda_s;
               default: ;
            endcase
         end else if (scl_fall) begin
            case (st_r)
               mms_pkg::ST_DEV: begin
                  if (byte_end) begin
                     st_r <= dev_hit ? mms_pkg::ST_DEV_ACK
                                     : mms_pkg::ST_IDLE;
                     oe_r <= dev_hit;
                  end
               end
               mms_pkg::ST_DEV_ACK, mms_pkg::ST_RD_ACK: begin
                  cnt_r <= 4'h0;
                  if (load_rd) begin
                     st_r  <= mms_pkg::ST_RD;
                     sh_r  <= rd_byte;
                     oe_r  <= !rd_byte[7];
                     ptr_r <= ptr_r + 8'h01;
                     if (ptr_r == mms_pkg::ADDR_FLAGS) cor_r <= 1'b1;
                  end else if (st_r == mms_pkg::ST_DEV_ACK) begin
                     st_r      <= mms_pkg::ST_WR;
                     ptr_set_r <= 1'b1;
                     oe_r      <= 1'b0;
                  end else begin
                     st_r <= mms_pkg::ST_IDLE;
                     oe_r <= 1'b0;
                  end
               end
               mms_pkg::ST_WR: begin
                  if (byte_end) begin
                     st_r      <= mms_pkg::ST_WR_ACK;
                     oe_r      <= 1'b1;
                     ptr_set_r <= 1'b0;
                     ptr_r     <= ptr_set_r ? sh_r : ptr_r + 8'h01;
                  end
               end
               mms_pkg::ST_WR_ACK: begin
                  st_r  <= mms_pkg::ST_WR;
                  cnt_r <= 4'h0;
                  oe_r  <= 1'b0;
               end
               mms_pkg::ST_RD: begin
                  if (byte_end) begin
                     st_r <= mms_pkg::ST_RD_ACK;
                     oe_r <= 1'b0;
                  end else begin
                     sh_r <= {sh_r[6:0], 1'b0};
                     oe_r <= !sh_r[6];
                  end
               end
               default: st_r <= mms_pkg::ST_IDLE;
            endcase
         end
      end
   end

   assign cor_fire = bus_on && stop_c && cor_r;

   ////////////////////////////////////////////////////////////////////////
   // Control registers and user storage
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r <= mms_pkg::CTRL_RST;
         mask_r <= mms_pkg::MASK_RST;
         page_r <= mms_pkg::PAGE_RST;
      end else if (hold_r) begin
         ctrl_r <= mms_pkg::CTRL_RST;
         mask_r <= mms_pkg::MASK_RST;
         page_r <= mms_pkg::PAGE_RST;
      end else if (wr_fire) begin
         if (ptr_r == mms_pkg::ADDR_CTRL) ctrl_r <= sh_r;
         if (ptr_r == mms_pkg::ADDR_MASK) mask_r <= sh_r[3:0];
         if (ptr_r == mms_pkg::ADDR_PAGE) page_r <= sh_r;
      end
   end

   always_ff @(posedge core_clk) begin
      if (wr_user) user_mem[ptr_r[6:0]] <= sh_r;
   end

   ////////////////////////////////////////////////////////////////////////
   // Flags, interrupt and power level
   wire [mms_pkg::NFLAG-1:0] flag_set = {init_done, cond_s[2:0]};

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         flag_r          <= '0;
         interrupt_out_n <= 1'b1;
         low_power_mode  <= 1'b0;
      end else begin
         if (hold_r) flag_r <= '0;
         else flag_r <= (flag_r & ~{mms_pkg::NFLAG{cor_fire}}) |
                        flag_set;
         interrupt_out_n <= ~|(flag_r & ~mask_r);
         low_power_mode  <= lps_s ||
                            ctrl_r[mms_pkg::CTRL_PDOWN];
      end
   end

   assign data_not_ready = dnr_r;
   assign sda_out        = 1'b0;
   assign sda_oe         = oe_r;

endmodule

// ===== mms_pkg.sv
// Constants, register map and types for the module management block.
// Assumes a 125 MHz core clock; all pin inputs are asynchronous to it.
package mms_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Timing
   localparam int CLK_MHZ       = 125;
   localparam int T_INIT_MS     = 2000;
   localparam int INIT_CYC      = T_INIT_MS * 1000 * CLK_MHZ;
   localparam int T_RESET_US    = 2;
   localparam int RESET_MIN_CYC = T_RESET_US * CLK_MHZ;
   localparam int RCNT_W        = 9;

   ////////////////////////////////////////////////////////////////////////
   // Two-wire bus map
   localparam logic [6:0] DEV_ADDR    = 7'h50;
   localparam logic [7:0] ADDR_STATUS = 8'h02;
   localparam logic [7:0] ADDR_FLAGS  = 8'h03;
   localparam logic [7:0] ADDR_CTRL   = 8'h5d;
   localparam logic [7:0] ADDR_MASK   = 8'h64;
   localparam logic [7:0] ADDR_PAGE   = 8'h7f;
   localparam logic [7:0] USER_PAGE   = 8'h02;
   localparam int         USER_DEPTH  = 128;

   ////////////////////////////////////////////////////////////////////////
   // Fields and reset values
   localparam int NFLAG      = 4;
   localparam int FLAG_LOS   = 0;
   localparam int FLAG_TXF   = 1;
   localparam int FLAG_OTH   = 2;
   localparam int FLAG_RDY   = 3;
   localparam int CTRL_PDOWN = 1;
   localparam int DNR_BIT    = 0;
   localparam logic [7:0]       CTRL_RST = 8'h00;
   localparam logic [NFLAG-1:0] MASK_RST = 4'h0;
   localparam logic [7:0]       PAGE_RST = 8'h00;

   ////////////////////////////////////////////////////////////////////////
   // Synchroniser lanes
   localparam int SI_SCL = 0;
   localparam int SI_SDA = 1;
   localparam int SI_RST = 2;
   localparam int SI_SEL = 3;
   localparam int SI_LPS = 4;
   localparam int SI_LOS = 5;
   localparam int SI_TXF = 6;
   localparam int SI_OTH = 7;
   localparam int NSYNC  = 8;
   localparam logic [NSYNC-1:0] SYNC_RST = 8'h0f;

   typedef enum logic [2:0] {
      ST_IDLE, ST_DEV, ST_DEV_ACK, ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK
   } mms_tw_state_type;

endpackage

// ===== mms_tmr_if.sv
// Interface between the control logic and its latency timer.
// Assumes both ends share core_clk.
`timescale 1ns/1ps
interface mms_tmr_if;
   logic start;
   logic busy;
   logic done;
   modport ctl (output start, input busy, input done);
   modport tmr (input start, output busy, output done);
endinterface

// ===== mms_sync.sv
// Two-flop synchroniser bank for asynchronous pin inputs.
// Assumes inputs are single-bit levels with no relation to core_clk.
`timescale 1ns/1ps
module mms_sync #(
   parameter int               W       = 8,
   parameter logic [W-1:0]     RST_VAL = '0
) (
   input  wire logic           core_clk,
   input  wire logic           rst_n,
   input  wire logic [W-1:0]   d_in,
   output logic      [W-1:0]   q_out
);

   logic [W-1:0] meta_r;

   for (genvar i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge core_clk or negedge rst_n) begin
         if (!rst_n) begin
            meta_r[i] <= RST_VAL[i];
            q_out[i]  <= RST_VAL[i];
         end else begin
            meta_r[i] <= d_in[i];
            q_out[i]  <= meta_r[i];
         end
      end
   end

endmodule

// ===== mms_timer.sv
// One-shot down counter giving a single-cycle done after CYCLES clocks.
// Assumes start is a pulse on core_clk; a new start reloads the count.
`timescale 1ns/1ps
module mms_timer #(
   parameter int CYCLES = 16
) (
   input  wire logic core_clk,
   input  wire logic rst_n,
   mms_tmr_if.tmr    tif
);

   logic [31:0] cnt_r;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= 32'h0;
      end else if (tif.start) begin
         cnt_r <= 32'(CYCLES);
      end else if (cnt_r != 32'h0) begin
         cnt_r <= cnt_r - 32'h1;
      end
   end

   assign tif.busy = (cnt_r != 32'h0);
   assign tif.done = (cnt_r == 32'h1);

endmodule

// ===== mms_props.sv
// Concurrent checks on the management block's pins.
// Assumes one core clock domain and a slow two-wire host.
`timescale 1ns/1ps
module mms_props #(
   parameter int INIT_CYCLES = 200
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic module_reset_n,
   input wire logic module_select_n,
   input wire logic low_power_select,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_oe,
   input wire logic interrupt_out_n,
   input wire logic low_power_mode,
   input wire logic data_not_ready
);
   logic [9:0]  low_cnt_r;
   logic [31:0] run_cnt_r;
   logic [3:0]  age_r;
   logic        sda_r;
   wire logic   evt = (scl_in & sda_in & ~sda_r) | sda_oe | ~module_reset_n;
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);
   ///////////////////////////////////////////////////////////////////////////
   // Reset pin low run, cycles since its release, age of last bus or reset-pin event
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         low_cnt_r <= 10'h0;
         run_cnt_r <= 32'h0;
         age_r     <= 4'h0;
         sda_r     <= 1'b1;
      end else begin
         low_cnt_r <= module_reset_n ? 10'h0 : low_cnt_r + 10'(~&low_cnt_r);
         run_cnt_r <= module_reset_n ? run_cnt_r + 32'(~&run_cnt_r) : 32'h0;
         age_r     <= evt ? 4'h0 : age_r + 4'(~&age_r);
         sda_r     <= sda_in;
      end
   end
   lp_pin_a: assert property (low_power_select [*5] |-> low_power_mode)
      else $error("low power pin ignored");
   sel_off_a: assert property (module_select_n [*8] |-> !sda_oe)
      else $error("bus answers while deselected");
   dnr_bus_a: assert property (data_not_ready [*4] |-> !sda_oe)
      else $error("bus answers before ready");
   rdy_irq_a: assert property (
      $fell(data_not_ready) |-> ##1 !interrupt_out_n)
      else $error("ready did not raise interrupt");
   init_len_a: assert property ($fell(data_not_ready) |->
      run_cnt_r >= INIT_CYCLES - 1 && run_cnt_r <= INIT_CYCLES + 8)
      else $error("init length wrong");
   mrst_short_a: assert property (
      $rose(data_not_ready) |-> low_cnt_r >= 10'(mms_pkg::RESET_MIN_CYC))
      else $error("short reset pulse recognised");
   mrst_hold_a: assert property (
      low_cnt_r == 10'h104 |-> data_not_ready && interrupt_out_n)
      else $error("held reset not recognised");
   irq_release_a: assert property ($rose(interrupt_out_n) |->
      (age_r <= 4'h8) or (##[0:12] sda_oe))
      else $error("interrupt released without cause");
endmodule

// ===== mms_host.sv
// Two-wire host controller model, 64 ns bus clock, SDA pulled up.
// Assumes the bench resolves the open-drain data line into sda_w.
`timescale 1ns/1ps
module mms_host (
   output logic      scl,
   output logic      sda_h,
   input  wire logic sda_w
);
   initial begin
      scl = 1'b1;
      sda_h = 1'b1;
   end
   task bit_io(input logic b, output logic r);
      sda_h = b;
      #16 scl = 1'b1;
      #16 r = sda_w;
      #16 scl = 1'b0;
      #16;
   endtask
   task start;
      sda_h = 1'b1;
      #16 scl = 1'b1;
      #16 sda_h = 1'b0;
      #16 scl = 1'b0;
      #16;
   endtask
   task stop;
      sda_h = 1'b0;
      #16 scl = 1'b1;
      #16 sda_h = 1'b1;
      #32;
   endtask
   task xb(input logic [7:0] d, input logic m, output logic [7:0] q,
           output logic a);
      for (int i = 7; i >= 0; i--)
         bit_io(d[i], q[i]);
      bit_io(m, a);
   endtask
   task wr(input logic [7:0] p, input logic [7:0] d, output logic ok);
      logic [7:0] q;
      logic       a0, a1, a2;
      start;
      xb({mms_pkg::DEV_ADDR, 1'b0}, 1'b1, q, a0);
      xb(p, 1'b1, q, a1);
      xb(d, 1'b1, q, a2);
      stop;
      ok = !(a0 | a1 | a2);
   endtask
   task rd(input logic [7:0] p, output logic [7:0] d, output logic ok);
      logic [7:0] q;
      logic       a0, a1, a2, a3;
      start;
      xb({mms_pkg::DEV_ADDR, 1'b0}, 1'b1, q, a0);
      xb(p, 1'b1, q, a1);
      start;
      xb({mms_pkg::DEV_ADDR, 1'b1}, 1'b1, q, a2);
      xb(8'hff, 1'b1, d, a3);
      stop;
      ok = !(a0 | a1 | a2);
   endtask
endmodule

// ===== mms_top_test.sv
// Self-checking bench for the management block with a host bus model.
// Assumes a short init count so that the run stays brief.
`timescale 1ns/1ps
module mms_top_test;
   localparam int INIT = 200;
   logic       core_clk = 1'b0;
   logic       rst_n = 1'b0;
   logic       module_reset_n = 1'b1;
   logic       module_select_n = 1'b0;
   logic       low_power_select = 1'b0;
   logic [2:0] cond = 3'h0;
   logic       sda_out, sda_oe, interrupt_out_n, low_power_mode;
   logic       data_not_ready, scl, sda_h, ok;
   logic [7:0] q, v, a;
   int         n_fail = 0;
   int         n_checks = 0;
   int         k;
   wire logic  sda_w = sda_h & (sda_oe ? sda_out : 1'b1);
   wire logic [2:0] obs = {low_power_mode, data_not_ready, interrupt_out_n};
   always #4 core_clk = ~core_clk;
   mms_top #(.INIT_CYCLES(INIT)) i_dut (
      .core_clk(core_clk), .rst_n(rst_n), .module_reset_n(module_reset_n),
      .module_select_n(module_select_n),
      .low_power_select(low_power_select), .scl_in(scl), .sda_in(sda_w),
      .sda_out(sda_out), .sda_oe(sda_oe), .rx_los(cond[0]),
      .tx_fault(cond[1]), .other_fault(cond[2]),
      .interrupt_out_n(interrupt_out_n), .low_power_mode(low_power_mode),
      .data_not_ready(data_not_ready)
   );
   mms_host i_host (.scl(scl), .sda_h(sda_h), .sda_w(sda_w));
   ///////////////////////////////////////////////////////////////////////////
   task results;
      $display("checks %0d failures %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         $display("BAD %s expected %h seen %h", nm, e, g);
         n_fail++;
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task wt(input int s, input logic e, input int n, input string nm);
      for (int i = 0; i < n && obs[s] !== e; i++)
         cyc(1);
      chk(nm, {7'h0, e}, {7'h0, obs[s]});
      if (obs[s] !== e)
         results();
   endtask
   task rdc(input logic [7:0] p, input logic [7:0] e, input string nm);
      i_host.rd(p, q, ok);
      chk("read_ack", 8'h01, {7'h0, ok});
      chk(nm, e, q);
   endtask
   task wrc(input logic [7:0] p, input logic [7:0] d);
      i_host.wr(p, d, ok);
      chk("write_ack", 8'h01, {7'h0, ok});
   endtask
   function automatic logic [7:0] fexp(input int b);
      return 8'h01 << b;
   endfunction
   initial begin
      void'($urandom(29217));
      cyc(2);
      rst_n = 1'b1;
      chk("dnr_reset", 8'h01, {7'h0, data_not_ready});
      wt(1, 1'b0, INIT + 10, "init_done");
      wt(0, 1'b0, 3, "ready_irq");
      rdc(mms_pkg::ADDR_STATUS, 8'h00, "status");
      rdc(mms_pkg::ADDR_FLAGS, fexp(mms_pkg::FLAG_RDY), "ready_flag");
      wt(0, 1'b1, 20, "irq_clear");
      for (k = 0; k < 3; k++) begin
         cond[k] = 1'b1;
         cyc(2 + $urandom_range(8));
         cond[k] = 1'b0;
         wt(0, 1'b0, 10, "cond_irq");
         rdc(mms_pkg::ADDR_FLAGS, fexp(k), "cond_flag");
         wt(0, 1'b1, 20, "cond_clear");
      end
      cond[0] = 1'b1;
      wt(0, 1'b0, 10, "los_irq");
      wrc(mms_pkg::ADDR_MASK, 8'h01);
      wt(0, 1'b1, 10, "mask_set");
      rdc(mms_pkg::ADDR_MASK, 8'h01, "mask_back");
      cond[0] = 1'b0;
      wrc(mms_pkg::ADDR_MASK, 8'h00);
      wt(0, 1'b0, 10, "mask_clr");
      rdc(mms_pkg::ADDR_FLAGS, 8'h01, "masked_flag");
      wt(0, 1'b1, 20, "mask_irq_clear");
      low_power_select = 1'b1;
      wt(2, 1'b1, 6, "lp_on");
      low_power_select = 1'b0;
      wt(2, 1'b0, 6, "lp_off");
      wrc(mms_pkg::ADDR_CTRL, 8'h02);
      wt(2, 1'b1, 6, "pdown_on");
      rdc(mms_pkg::ADDR_CTRL, 8'h02, "ctrl_back");
      wrc(mms_pkg::ADDR_CTRL, 8'h00);
      wt(2, 1'b0, 6, "pdown_off");
      module_select_n = 1'b1;
      cyc(8);
      i_host.wr(mms_pkg::ADDR_PAGE, mms_pkg::USER_PAGE, ok);
      chk("deselect", 8'h00, {7'h0, ok});
      cyc(1);
      module_select_n = 1'b0;
      cyc(8);
      wrc(mms_pkg::ADDR_PAGE, mms_pkg::USER_PAGE);
      a = 8'h80 | 8'($urandom_range(127));
      v = 8'($urandom);
      wrc(a, v);
      rdc(a, v, "user_ram");
      wrc(mms_pkg::ADDR_PAGE, 8'h00);
      rdc(a, 8'h00, "other_page");
      wrc(mms_pkg::ADDR_PAGE, mms_pkg::USER_PAGE);
      cyc(1);
      module_reset_n = 1'b0;
      cyc(100);
      module_reset_n = 1'b1;
      cyc(4);
      chk("short_pulse", 8'h00, {7'h0, data_not_ready});
      rdc(mms_pkg::ADDR_PAGE, mms_pkg::USER_PAGE, "page_kept");
      module_reset_n = 1'b0;
      cyc(mms_pkg::RESET_MIN_CYC + 20);
      chk("reset_held", 8'h01, {7'h0, data_not_ready});
      module_reset_n = 1'b1;
      wt(1, 1'b0, INIT + 10, "reinit");
      wt(0, 1'b0, 3, "reinit_irq");
      rdc(mms_pkg::ADDR_PAGE, 8'h00, "page_cleared");
      results();
   end
endmodule
bind mms_top mms_props #(.INIT_CYCLES(INIT_CYCLES)) i_props (
   .core_clk, .rst_n, .module_reset_n, .module_select_n, .low_power_select,
   .scl_in, .sda_in, .sda_oe, .interrupt_out_n, .low_power_mode,
   .data_not_ready
);
